// *** verilog/nvp_map.svh ***
`ifndef NVP_MAP_SVH
`define NVP_MAP_SVH

// ----------------------------------------
// memory controller command codes and fields
// ----------------------------------------
`define NVP_CMD_NOP 6'h00
`define NVP_CMD_CHIP_ERASE 6'h10
`define NVP_CMD_SECT_ERASE 6'h14
`define NVP_CMD_WRITE_TWO 6'h1D
`define NVP_BUSY_BIT 7
`define NVP_EN_BIT 1
`define NVP_IO_CMD 6'h33
`define NVP_IO_CSR 6'h32
`define NVP_CODE_BASE 16'h4000
`define NVP_ERASED 16'hFFFF
`define NVP_KEY_LAST 3'h7

// ----------------------------------------
// link operation codes
// ----------------------------------------
`define NVP_OP_NONE 3'h0
`define NVP_OP_KEY 3'h1
`define NVP_OP_IOW 3'h2
`define NVP_OP_IOR 3'h3
`define NVP_OP_DW 3'h4
`define NVP_OP_DR 3'h5
`define NVP_OP_LSW 3'h6
`define NVP_OP_LSR 3'h7

// ----------------------------------------
// programmer command port registers and bits
// ----------------------------------------
`define NVP_H_ADDR_LO 3'h0
`define NVP_H_ADDR_HI 3'h1
`define NVP_H_DATA 3'h2
`define NVP_H_CTRL 3'h3
`define NVP_H_GO 3'h4
`define NVP_H_STAT 3'h5
`define NVP_H_RDATA 3'h6
`define NVP_CTRL_LINK 0
`define NVP_CTRL_RST 1
`define NVP_STAT_PEND 0
`define NVP_STAT_EN 1
`define NVP_STAT_ERR 2

`endif

// *** verilog/nvp_pkg.sv ***
`default_nettype none
package nvp_pkg;
    typedef logic [2:0] nvp_op_t;
    typedef logic [15:0] nvp_addr_t;
    typedef logic [7:0] nvp_byte_t;
    typedef logic [15:0] nvp_word_t;
    typedef enum logic [1:0] {JOB_NONE, JOB_CHIP, JOB_SECT, JOB_WRITE} nvp_job_t;
endpackage : nvp_pkg
`default_nettype wire

// *** verilog/nvp_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// programming link, one transfer per req pulse, read answer one cycle later
interface nvp_if;
    logic link_en;
    logic rst_hold;
    logic req;
    nvp_pkg::nvp_op_t op;
    nvp_pkg::nvp_addr_t addr;
    nvp_pkg::nvp_byte_t wdata;
    logic rvalid;
    nvp_pkg::nvp_byte_t rdata;
    modport dev (input link_en, rst_hold, req, op, addr, wdata, output rvalid, rdata);
    modport host (output link_en, rst_hold, req, op, addr, wdata, input rvalid, rdata);
endinterface : nvp_if
`default_nettype wire

// *** verilog/nvp_dev.sv ***
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "nvp_map.svh"

module nvp_dev #(
    parameter int WORDS = 16,
    parameter logic [15:0] ERASE_CYC = 16'h00C8,
    parameter logic [15:0] WRITE_CYC = 16'h0032,
    parameter logic [63:0] ACCESS_KEY = 64'h0123_4567_89AB_CDEF // arbitrary value
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    nvp_if.dev link,
    output logic busy_out,
    output logic prog_en_out
);
    import nvp_pkg::*;

    localparam int AW = $clog2(WORDS);

    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    if (WORDS < 4 || (1 << AW) != WORDS || WORDS > 16384) begin : g_chk_words
        $error("WORDS must be a power of two from 4 to 16384");
    end
    if (ERASE_CYC == 16'h0000 || WRITE_CYC == 16'h0000) begin : g_chk_cyc
        $error("busy counts must be non-zero");
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic link_on;
    logic [63:0] key_q;
    logic [2:0] key_cnt_q;
    logic en_q;
    logic [5:0] cmd_q;
    logic busy_q;
    logic [15:0] cnt_q;
    nvp_job_t job_q;
    nvp_byte_t lo_q;
    logic half_q;
    nvp_word_t w0_q;
    nvp_word_t w1_q;
    logic [AW-2:0] pair_q;
    nvp_word_t mem_q [WORDS];
    nvp_byte_t rdata_q;
    logic rvalid_q;

    // ----------------------------------------
    // decode of the current link transfer
    // ----------------------------------------
    nvp_addr_t off;
    logic is_code;
    logic [AW-1:0] widx;
    logic hi;
    logic mem_wr;
    logic cmd_wr;
    logic start_erase;
    logic last_hi;
    logic done;

    // programming is only live while the link runs and reset is held
    assign link_on = link.link_en && link.rst_hold;

    always_comb begin
        off = link.addr - `NVP_CODE_BASE;
        is_code = (link.addr >= `NVP_CODE_BASE) && (off < 16'(2 * WORDS));
        widx = off[AW:1];
        hi = off[0];
    end

    // mapped writes count only when enabled and idle; busy blocks all of them
    assign mem_wr = link.req && link.op == `NVP_OP_DW && en_q && !busy_q && is_code;
    assign cmd_wr = link.req && link.op == `NVP_OP_IOW && en_q && !busy_q
        && link.addr[5:0] == `NVP_IO_CMD;
    // both erase codes start on a high-byte write; other codes start no erase
    assign start_erase = mem_wr && hi
        && (cmd_q == `NVP_CMD_CHIP_ERASE || cmd_q == `NVP_CMD_SECT_ERASE);
    assign last_hi = mem_wr && hi && half_q && cmd_q == `NVP_CMD_WRITE_TWO;
    assign done = busy_q && cnt_q == 16'h0000;

    // ----------------------------------------
    // access key and programming enable
    // ----------------------------------------
    // key bytes are shifted in lowest first; a full match sets the enable
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            key_q <= 64'h0;
            key_cnt_q <= 3'h0;
            en_q <= 1'b0;
        end else if (!link_on) begin
            key_cnt_q <= 3'h0;
            en_q <= 1'b0;
        end else if (link.req && link.op == `NVP_OP_KEY) begin
            key_q <= {link.wdata, key_q[63:8]};
            key_cnt_q <= key_cnt_q + 3'h1;
            if (key_cnt_q == `NVP_KEY_LAST && {link.wdata, key_q[63:8]} == ACCESS_KEY) begin
                en_q <= 1'b1;
            end
        end else if (link.req && link.op == `NVP_OP_LSW) begin
            en_q <= en_q && link.wdata[`NVP_EN_BIT]; // software may only clear it
        end
    end

    // ----------------------------------------
    // command register
    // ----------------------------------------
    // undefined codes are kept so they read back, but decode to nothing
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cmd_q <= `NVP_CMD_NOP;
        end else if (cmd_wr) begin
            cmd_q <= link.wdata[5:0];
        end
    end

    // ----------------------------------------
    // two-word staging buffer
    // ----------------------------------------
    // a pair sits on an even word; the second word goes to the odd one after it
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            lo_q <= 8'h00;
            half_q <= 1'b0;
            w0_q <= `NVP_ERASED;
            w1_q <= `NVP_ERASED;
            pair_q <= '0;
        end else if (cmd_wr) begin
            half_q <= 1'b0;
        end else if (mem_wr && cmd_q == `NVP_CMD_WRITE_TWO) begin
            if (!hi) begin
                lo_q <= link.wdata;
            end else if (!half_q) begin
                w0_q <= {link.wdata, lo_q};
                pair_q <= widx[AW-1:1];
                half_q <= 1'b1;
            end else begin
                w1_q <= {link.wdata, lo_q};
                half_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // busy flag and operation timer
    // ----------------------------------------
    // busy rises with the starting write and falls on the same edge as the array update
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            busy_q <= 1'b0;
            cnt_q <= 16'h0000;
            job_q <= JOB_NONE;
        end else if (start_erase) begin
            busy_q <= 1'b1;
            cnt_q <= ERASE_CYC - 16'h0001;
            job_q <= (cmd_q == `NVP_CMD_CHIP_ERASE) ? JOB_CHIP : JOB_SECT;
        end else if (last_hi) begin
            busy_q <= 1'b1;
            cnt_q <= WRITE_CYC - 16'h0001;
            job_q <= JOB_WRITE;
        end else if (done) begin
            busy_q <= 1'b0;
            job_q <= JOB_NONE;
        end else if (busy_q) begin
            cnt_q <= cnt_q - 16'h0001;
        end
    end

    // ----------------------------------------
    // flash array
    // ----------------------------------------
    // writing only pulls bits low, so an unerased word ends up corrupted
    for (genvar i = 0; i < WORDS; i++) begin : g_word
        always_ff @(posedge clk_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
                mem_q[i] <= `NVP_ERASED;
            end else if (done && (job_q == JOB_CHIP || job_q == JOB_SECT)) begin
                mem_q[i] <= `NVP_ERASED;
            end else if (done && job_q == JOB_WRITE && (AW-1)'(i >> 1) == pair_q) begin
                mem_q[i] <= mem_q[i] & (((i % 2) == 1) ? w1_q : w0_q);
            end
        end
    end

    // ----------------------------------------
    // read answers
    // ----------------------------------------
    // every read op answers next cycle; inhibited or unmapped reads give zero
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= link.req && (link.op == `NVP_OP_IOR || link.op == `NVP_OP_DR
                || link.op == `NVP_OP_LSR);
            rdata_q <= 8'h00;
            if (link.req && link.op == `NVP_OP_LSR) begin
                rdata_q[`NVP_EN_BIT] <= en_q;
            end else if (link.req && link.op == `NVP_OP_IOR) begin
                if (link.addr[5:0] == `NVP_IO_CMD) begin
                    rdata_q <= {2'b00, cmd_q};
                end else if (link.addr[5:0] == `NVP_IO_CSR) begin
                    rdata_q[`NVP_BUSY_BIT] <= busy_q;
                end
            end else if (link.req && link.op == `NVP_OP_DR && en_q && !busy_q && is_code) begin
                rdata_q <= hi ? mem_q[widx][15:8] : mem_q[widx][7:0];
            end
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign link.rdata = rdata_q;
    assign link.rvalid = rvalid_q;
    assign busy_out = busy_q;
    assign prog_en_out = en_q;

endmodule : nvp_dev
`default_nettype wire

// *** verilog/nvp_host.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "nvp_map.svh"

module nvp_host (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    nvp_if.host link
);
    import nvp_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    nvp_addr_t addr_q;
    nvp_byte_t data_q;
    logic link_en_q;
    logic rst_hold_q;
    logic req_q;
    nvp_op_t op_q;
    logic pend_q;
    logic en_seen_q;
    logic err_q;
    nvp_byte_t last_q;
    nvp_byte_t rdata_q;
    logic go;
    logic ok;
    nvp_op_t go_op;

    // ----------------------------------------
    // legality of a requested transfer
    // ----------------------------------------
    assign go = wr_in && addr_in == `NVP_H_GO;
    assign go_op = wdata_in[2:0];
    always_comb begin
        ok = !pend_q && link_en_q;
        if (go_op == `NVP_OP_KEY || go_op == `NVP_OP_LSR || go_op == `NVP_OP_LSW) begin
            ok = ok && rst_hold_q;
        end else if (go_op == `NVP_OP_NONE) begin
            ok = 1'b0;
        end else begin
            ok = ok && en_seen_q;
        end
    end

    // ----------------------------------------
    // software registers and link drive
    // ----------------------------------------
    // reset may only be released once the enable is known to be cleared
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            addr_q <= 16'h0000;
            data_q <= 8'h00;
            link_en_q <= 1'b0;
            rst_hold_q <= 1'b0;
            err_q <= 1'b0;
        end else if (wr_in) begin
            case (addr_in)
                `NVP_H_ADDR_LO: addr_q[7:0] <= wdata_in;
                `NVP_H_ADDR_HI: addr_q[15:8] <= wdata_in;
                `NVP_H_DATA: data_q <= wdata_in;
                `NVP_H_CTRL: begin
                    link_en_q <= wdata_in[`NVP_CTRL_LINK];
                    if (en_seen_q && !wdata_in[`NVP_CTRL_RST]) begin
                        err_q <= 1'b1;
                    end else begin
                        rst_hold_q <= wdata_in[`NVP_CTRL_RST];
                    end
                end
                `NVP_H_GO: if (!ok) err_q <= 1'b1;
                `NVP_H_STAT: err_q <= 1'b0;
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // transfer issue and answer capture
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            req_q <= 1'b0;
            op_q <= `NVP_OP_NONE;
            pend_q <= 1'b0;
            last_q <= 8'h00;
        end else begin
            req_q <= go && ok;
            if (go && ok) begin
                op_q <= go_op;
                pend_q <= go_op == `NVP_OP_IOR || go_op == `NVP_OP_DR || go_op == `NVP_OP_LSR;
            end else if (link.rvalid) begin
                pend_q <= 1'b0;
                last_q <= link.rdata;
            end
        end
    end

    // ----------------------------------------
    // enable flag as last seen over the link
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            en_seen_q <= 1'b0;
        end else if (!link_en_q) begin
            en_seen_q <= 1'b0;
        end else if (link.rvalid && op_q == `NVP_OP_LSR) begin
            en_seen_q <= link.rdata[`NVP_EN_BIT];
        end else if (req_q && op_q == `NVP_OP_LSW && !data_q[`NVP_EN_BIT]) begin
            en_seen_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // register read port, data one cycle after the strobe
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_q <= 8'h00;
        end else if (rd_in) begin
            case (addr_in)
                `NVP_H_ADDR_LO: rdata_q <= addr_q[7:0];
                `NVP_H_ADDR_HI: rdata_q <= addr_q[15:8];
                `NVP_H_DATA: rdata_q <= data_q;
                `NVP_H_CTRL: rdata_q <= {6'h00, rst_hold_q, link_en_q};
                `NVP_H_STAT: rdata_q <= {5'h00, err_q, en_seen_q, pend_q};
                `NVP_H_RDATA: rdata_q <= last_q;
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign rdata_out = rdata_q;
    assign link.link_en = link_en_q;
    assign link.rst_hold = rst_hold_q;
    assign link.req = req_q;
    assign link.op = op_q;
    assign link.addr = addr_q;
    assign link.wdata = data_q;

endmodule : nvp_host
`default_nettype wire

// *** bench/nvp_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "nvp_map.svh"

module nvp_properties (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic link_en,
    input wire logic rst_hold,
    input wire logic req,
    input wire nvp_pkg::nvp_op_t op,
    input wire nvp_pkg::nvp_addr_t addr,
    input wire nvp_pkg::nvp_byte_t wdata,
    input wire logic rvalid,
    input wire nvp_pkg::nvp_byte_t rdata
);
    import nvp_pkg::*;

    // ----------------------------------------
    // link transfer sequences
    // ----------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);

    // a write only has effect while the link is up and the device is held; the device answers reads in any state
    sequence s_live_req;
        req && link_en && rst_hold;
    endsequence
    sequence s_read_req;
        s_live_req ##0 (op inside {`NVP_OP_IOR, `NVP_OP_DR, `NVP_OP_LSR});
    endsequence
    sequence s_cmd_read;
        s_read_req ##0 (op == `NVP_OP_IOR && addr[5:0] == `NVP_IO_CMD);
    endsequence
    sequence s_csr_read;
        s_read_req ##0 (op == `NVP_OP_IOR && addr[5:0] == `NVP_IO_CSR);
    endsequence

    // ----------------------------------------
    // checks on the link wires
    // ----------------------------------------
    a_read_answer_next: assert property (s_read_req |=> rvalid)
        else $error("read request got no answer in the next cycle");
    a_answer_has_cause: assert property (rvalid |-> $past(req) &&
        ($past(op) inside {`NVP_OP_IOR, `NVP_OP_DR, `NVP_OP_LSR}))
        else $error("answer without a read request before it");
    a_idle_data_zero: assert property (!rvalid |-> rdata == 8'h00)
        else $error("read data not zero outside an answer");
    a_req_one_cycle: assert property (req |=> !req)
        else $error("request held longer than one cycle");
    a_req_has_op: assert property (req |-> op != `NVP_OP_NONE)
        else $error("request without a transfer kind");
    a_key_needs_link: assert property (req && op == `NVP_OP_KEY |-> link_en && rst_hold)
        else $error("key byte sent before link and reset hold");
    a_mem_needs_link: assert property (req && (op inside {`NVP_OP_IOW, `NVP_OP_IOR,
        `NVP_OP_DW, `NVP_OP_DR}) |-> link_en && rst_hold)
        else $error("memory access outside programming mode");
    a_cmd_top_zero: assert property (s_cmd_read |=> rdata[7:6] == 2'b00)
        else $error("command upper bits not zero");
    a_csr_low_zero: assert property (s_csr_read |=> rdata[6:0] == 7'h00)
        else $error("status low bits not zero");
endmodule : nvp_properties
`default_nettype wire

// *** bench/tb_nvm_external_program_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "nvp_map.svh"

module tb_nvm_external_program_ctrl;
    import nvp_pkg::*;
    localparam logic [63:0] KEY = 64'hA5C3_1E0F_7B29_D468; // arbitrary value
    localparam logic [15:0] WCYC = 16'h0078; // long enough to probe a running write
    localparam logic [15:0] ECYC = 16'h0096;
    localparam nvp_addr_t CMD_A = {10'h000, `NVP_IO_CMD};
    localparam nvp_addr_t CSR_A = {10'h000, `NVP_IO_CSR};
    localparam logic [7:0] DAT [4] = '{8'h12, 8'h34, 8'h56, 8'h78};
    localparam logic [7:0] ERASES [2] = '{8'h10, 8'h14};
    localparam logic [7:0] NOPS [2] = '{8'hFF, 8'h00};
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic [2:0] addr_in = 3'h0;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [7:0] rdata_out;
    logic busy_out;
    logic prog_en_out;
    int err_count = 0;
    int check_count = 0;
    int busy_cnt = 0;
    int busy_len = 0;

    // ----------------------------------------
    // clock, design and checker
    // ----------------------------------------
    always #5 clk_in = ~clk_in;

    nvp_if u_nvp_if ();
    nvp_host u_nvp_host (.clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .link(u_nvp_if.host));
    nvp_dev #(.WORDS(16), .ERASE_CYC(ECYC), .WRITE_CYC(WCYC), .ACCESS_KEY(KEY)) u_nvp_dev (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .link(u_nvp_if.dev), .busy_out(busy_out),
        .prog_en_out(prog_en_out));
    nvp_properties u_nvp_properties (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .link_en(u_nvp_if.link_en), .rst_hold(u_nvp_if.rst_hold), .req(u_nvp_if.req),
        .op(u_nvp_if.op), .addr(u_nvp_if.addr), .wdata(u_nvp_if.wdata),
        .rvalid(u_nvp_if.rvalid), .rdata(u_nvp_if.rdata));

    // length of the last busy run, kept so each job's duration can be compared
    always @(posedge clk_in) begin
        if (busy_out === 1'b1) begin
            busy_cnt <= busy_cnt + 1;
        end else if (busy_cnt != 0) begin
            busy_len <= busy_cnt;
            busy_cnt <= 0;
        end
    end

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    // a gap cycle after each write keeps the strobe from being driven twice in one step
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        @(posedge clk_in);
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 v = rdata_out;
        @(posedge clk_in);
    endtask : rd

    // one link transfer through the command port, then fetch the last read byte
    task automatic link_op(input nvp_op_t op, input nvp_addr_t a, input logic [7:0] d,
        output logic [7:0] v);
        logic [7:0] s;
        int n;
        n = 0;
        wr(`NVP_H_ADDR_LO, a[7:0]);
        wr(`NVP_H_ADDR_HI, a[15:8]);
        wr(`NVP_H_DATA, d);
        wr(`NVP_H_GO, {5'h00, op});
        do begin
            rd(`NVP_H_STAT, s);
            n++;
        end while (s[`NVP_STAT_PEND] !== 1'b0 && n < 40);
        check({15'h0000, s[`NVP_STAT_PEND]}, 16'h0000, "link transfer stuck");
        rd(`NVP_H_RDATA, v);
    endtask : link_op

    task automatic stat_is(input logic [7:0] exp, input string msg);
        logic [7:0] s;
        rd(`NVP_H_STAT, s);
        check({8'h00, s}, {8'h00, exp}, msg);
        wr(`NVP_H_STAT, 8'h00);
    endtask : stat_is

    task automatic wait_idle;
        int n;
        n = 0;
        while (busy_out === 1'b1 && n < 400) begin
            @(posedge clk_in);
            n++;
        end
        @(posedge clk_in);
    endtask : wait_idle

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin : main_seq
        logic [7:0] v;
        repeat (2) @(posedge clk_in);
        arst_n_in <= 1'b1;
        @(posedge clk_in);
        link_op(`NVP_OP_KEY, 16'h0000, KEY[7:0], v);
        stat_is(8'h04, "key taken with link off");
        wr(`NVP_H_CTRL, 8'h03);
        link_op(`NVP_OP_IOR, CMD_A, 8'h00, v);
        stat_is(8'h04, "io read taken before enable");
        for (int i = 0; i < 8; i++) link_op(`NVP_OP_KEY, 16'h0000, KEY[8*i +: 8], v);
        link_op(`NVP_OP_LSR, 16'h0000, 8'h00, v);
        check({15'h0000, v[`NVP_EN_BIT]}, 16'h0001, "enable flag after key");
        check({15'h0000, prog_en_out}, 16'h0001, "programming enable output");
        link_op(`NVP_OP_IOR, CMD_A, 8'h00, v);
        check({8'h00, v}, 16'h0000, "command after reset");
        link_op(`NVP_OP_IOR, CSR_A, 8'h00, v);
        check({8'h00, v}, 16'h0000, "status after reset");
        $display("test entry done");
        // codes that must leave the memory alone
        foreach (NOPS[k]) begin
            link_op(`NVP_OP_IOW, CMD_A, NOPS[k], v);
            link_op(`NVP_OP_IOR, CMD_A, 8'h00, v);
            check({8'h00, v}, {10'h000, NOPS[k][5:0]}, "command readback");
            link_op(`NVP_OP_DW, 16'h4001, 8'h00, v);
            check({15'h0000, busy_out}, 16'h0000, "no-op started a job");
            link_op(`NVP_OP_DR, 16'h4001, 8'h00, v);
            check({8'h00, v}, 16'h00FF, "no-op altered memory");
        end
        $display("test no-operation done");
        // write two words, then erase them with each erase code
        for (int k = 0; k < 2; k++) begin
            link_op(`NVP_OP_IOW, CMD_A, 8'h1D, v);
            for (int b = 0; b < 4; b++) begin
                link_op(`NVP_OP_DW, 16'h4004 + 16'(b), DAT[b], v);
                check({15'h0000, busy_out}, {15'h0000, 1'(b == 3)}, "busy start");
            end
            if (k == 0) begin
                link_op(`NVP_OP_IOW, CMD_A, 8'h10, v);
                link_op(`NVP_OP_IOR, CMD_A, 8'h00, v);
                check({8'h00, v}, 16'h001D, "command changed while busy");
                link_op(`NVP_OP_IOR, CSR_A, 8'h00, v);
                check({8'h00, v}, 16'h0080, "status while busy");
                link_op(`NVP_OP_DR, 16'h4004, 8'h00, v);
                check({8'h00, v}, 16'h0000, "memory read while busy");
            end
            wait_idle();
            check(16'(busy_len), WCYC, "write busy length");
            for (int b = 0; b < 4; b++) begin
                link_op(`NVP_OP_DR, 16'h4004 + 16'(b), 8'h00, v);
                check({8'h00, v}, {8'h00, DAT[b]}, "written byte");
            end
            link_op(`NVP_OP_IOW, CMD_A, ERASES[k], v);
            link_op(`NVP_OP_DW, 16'h4007, 8'h00, v);
            check({15'h0000, busy_out}, 16'h0001, "erase did not start");
            wait_idle();
            check(16'(busy_len), ECYC, "erase busy length");
            link_op(`NVP_OP_DR, 16'h4006, 8'h00, v);
            check({8'h00, v}, 16'h00FF, "byte not erased");
        end
        $display("test write and erase done");
        // reset release is held back until the enable flag is cleared
        wr(`NVP_H_CTRL, 8'h01);
        link_op(`NVP_OP_LSR, 16'h0000, 8'h00, v);
        check({15'h0000, v[`NVP_EN_BIT]}, 16'h0001, "enable lost on early release");
        link_op(`NVP_OP_LSW, 16'h0000, 8'h00, v);
        check({15'h0000, prog_en_out}, 16'h0000, "enable not cleared");
        $display("test exit done");
        wrap_up();
    end

    // cuts a hang short; the full run needs well under a fifth of this span
    initial begin : watchdog
        #100000;
        err_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        wrap_up();
    end
endmodule : tb_nvm_external_program_ctrl
`default_nettype wire
